// ### hw/thc_top.sv
// Purpose: tdm highway global mode, clocking and status with a wishbone register port
// Assumes: pins and reference input are synchronous to i_mclk; wishbone classic slave
// Notes: command word written at the command offset; status interrupts sticky, write one to clear
// Summary of operation
// - opcode 1001 command; clock mode in 23:16
// - mode three up: drive divided clock, 8k sync
// - mode zero: clock input, 8 kHz sync supplied
// - mode one: clock input, any sync rate
// - bit 15 reports highway status immediately, only with bit 14 set
// - bit 14 enables the status interrupt
// - bit 13 picks open drain or push pull
// - bit 12 picks frame sync sampling edge
// - master: bit 11 picks sync drive edge
// - master: count plus one pulses per frame
// - short count: clock stays low until frame
// - frame stays 125 us regardless of count
// - slave modes ignore the pulse count
// - first clock cycle precedes frame sync
// - slot cycles counted from frame start
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`default_nettype none

module thc_top
	import thc_pkg::*;
#(
	parameter int unsigned FRAME_CYC_P = FRAME_CYC, // system clocks per frame
	parameter int unsigned FS_TOL_P = FS_TOL_CYC // allowed frame interval deviation
)
(
	input wire logic i_mclk, // system clock
	input wire logic i_rst_b, // async reset, active low
	input wire logic i_wb_cyc, // wishbone cycle
	input wire logic i_wb_stb, // wishbone strobe
	input wire logic i_wb_we, // wishbone write
	input wire logic [ADR_W-1:0] i_wb_adr, // wishbone byte address
	input wire logic [3:0] i_wb_sel, // wishbone byte enables
	input wire logic [31:0] i_wb_dat, // wishbone write data
	output logic [31:0] o_wb_dat, // wishbone read data
	output logic o_wb_ack, // wishbone acknowledge
	input wire logic i_ref_clk, // 12.288 MHz reference
	input wire logic i_highway_bit_clock, // bit clock pin level
	output logic o_highway_bit_clock, // bit clock drive value
	output logic o_highway_bit_clock_oe_b, // bit clock enable, low drives
	input wire logic i_highway_frame_sync, // frame sync pin level
	output logic o_highway_frame_sync, // frame sync drive value
	output logic o_highway_frame_sync_oe_b, // frame sync enable, low drives
	input wire logic i_tx_bit, // data bit to put on the highway
	output logic o_highway_transmit_data, // transmit data drive value
	output logic o_highway_transmit_data_oe_b, // transmit data enable, low drives
	output logic [CYC_W-1:0] o_slot_cycle, // bit clock count in frame
	output logic o_frame_start, // one cycle at each frame start
	output logic o_irq // level interrupt
);
	// interval counter reaches two frame times, the point where lock is lost
	localparam int FRW = $clog2(2 * FRAME_CYC_P + 1);

	typedef struct packed
	{
		logic [31:0] cmd;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic ack;
		logic [31:0] dat;
		logic ref_s;
		logic ref_p;
		logic bck_s;
		logic fs_s;
		logic bck_p;
		logic fs_smp;
		logic [CYC_W-1:0] cyc;
		logic [FRW-1:0] ivl;
		logic locked;
		logic rate_err;
		logic bck_o;
		logic bck_oe_b;
		logic fs_o;
		logic fs_oe_b;
		logic txd_o;
		logic txd_oe_b;
		logic frame_start;
		logic irq;
	} thc_top_s;

	thc_top_s q;
	thc_top_s n;
	thc_gen_if gen_if ();

	logic master;
	logic bck_eff;
	logic fs_eff;
	logic smp_edge;
	logic req;
	logic [31:0] wmerge;
	logic [IRQ_W-1:0] clr;
	logic [IRQ_W-1:0] set;
	logic [FRW-1:0] lo_lim;
	logic [FRW-1:0] hi_lim;

	// clock mode field of a command word
	function automatic logic [7:0] thc_mode_of(input logic [31:0] c);
		return c[CMD_MODE_HI:CMD_MODE_LO];
	endfunction : thc_mode_of

	// mode decode; a value of two falls to the slave side
	// so a stray mode two never drives the highway against a far master
	assign master = thc_is_master(thc_mode_of(q.cmd));

	// generator configuration, run only as master
	// stopping the generator in slave modes is what makes the pulse count inert there
	assign gen_if.run = master;
	assign gen_if.div = thc_mode_of(q.cmd);
	assign gen_if.bits_per_frame_count = q.cmd[CMD_BPF_HI:CMD_BPF_LO];
	assign gen_if.drive_rise = q.cmd[CMD_DRIVE_EDGE];
	assign gen_if.ref_tick = q.ref_s & ~q.ref_p;

	thc_clkgen #(
		.FRAME_CYC_P(FRAME_CYC_P)
	) u_clkgen (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.gen(gen_if.gen)
	);

	// frame interval window for the fixed 8 kHz mode
	// the tolerance absorbs the jitter of a far clock against ours
	assign lo_lim = FRW'(FRAME_CYC_P - FS_TOL_P);
	assign hi_lim = FRW'(FRAME_CYC_P + FS_TOL_P);

	// next state of the control core
	always_comb
	begin
		n = q;
		set = '0;
		clr = '0;
		wmerge = 32'h0;
		// a strobe held through the ack is not taken twice
		req = i_wb_cyc & i_wb_stb & ~q.ack;

		// pin and reference sampling
		// the reference edge is found one sample late; only its rate matters
		n.ref_p = q.ref_s;
		n.ref_s = i_ref_clk;
		n.bck_s = i_highway_bit_clock;
		n.fs_s = i_highway_frame_sync;

		// master uses its own clock and sync, slave the pins
		bck_eff = master ? gen_if.bck : q.bck_s;
		fs_eff = master ? gen_if.fs : q.fs_s;
		n.bck_p = bck_eff;
		smp_edge = q.cmd[CMD_SAMPLE_EDGE] ? (bck_eff & ~q.bck_p) : (~bck_eff & q.bck_p);

		// frame interval, loss of lock after two frames of silence
		n.frame_start = 1'b0;
		// saturating, so a dead highway cannot wrap back into the window
		if (q.ivl != '1)
			n.ivl = q.ivl + 1'b1;
		if (q.ivl >= FRW'(2 * FRAME_CYC_P))
			n.locked = 1'b0;

		// rising bit clock edges count slot cycles
		// the count holds at all ones on an overlong frame instead of wrapping
		if (bck_eff & ~q.bck_p & (q.cyc != '1))
			n.cyc = q.cyc + 1'b1;
		if (smp_edge)
		begin
			n.fs_smp = fs_eff;
			// a frame starts where sync is first seen high at the chosen edge
			if (fs_eff & ~q.fs_smp)
			begin
				n.frame_start = 1'b1;
				n.cyc = '0;
				n.ivl = '0;
				n.locked = 1'b1;
				// only the fixed rate mode checks the interval
				// the first frame after lock has no interval worth judging
				if (thc_mode_of(q.cmd) == MODE_SLAVE_8K && q.locked)
					n.rate_err = (q.ivl < lo_lim) | (q.ivl > hi_lim);
				else
					n.rate_err = 1'b0;
			end
		end

		// status change raises the interrupt only when enabled
		if (q.cmd[CMD_IRQ_EN] && ({n.rate_err, n.locked} != {q.rate_err, q.locked}))
			set[IRQ_HWY_STATUS] = 1'b1;

		// wishbone slave, one cycle answer
		n.ack = req;
		if (req)
		begin
			case (i_wb_adr)
				REG_CMD:
				begin
					n.dat = q.cmd;
					if (i_wb_we)
					begin
						wmerge = thc_merge(q.cmd, i_wb_dat, i_wb_sel);
						// a foreign opcode leaves the stored word untouched
						if (wmerge[CMD_OPC_HI:CMD_OPC_LO] == CMD_OPCODE)
						begin
							n.cmd = wmerge;
							// the report bit is a strobe and is never stored
							n.cmd[CMD_REPORT] = 1'b0;
							// a report is issued only while the new word enables the interrupt
							if (wmerge[CMD_REPORT] && wmerge[CMD_IRQ_EN])
								set[IRQ_HWY_STATUS] = 1'b1;
						end
						else
							set[IRQ_CMD_REJECT] = 1'b1;
					end
				end
				REG_IRQ_STAT:
				begin
					n.dat = {{(32-IRQ_W){1'b0}}, q.irq_stat};
					// ones clear, but only in the enabled byte lanes
					if (i_wb_we)
					begin
						wmerge = thc_merge(32'h0, i_wb_dat, i_wb_sel);
						clr = wmerge[IRQ_W-1:0];
					end
				end
				REG_IRQ_MASK:
				begin
					n.dat = {{(32-IRQ_W){1'b0}}, q.irq_mask};
					if (i_wb_we)
					begin
						wmerge = thc_merge({{(32-IRQ_W){1'b0}}, q.irq_mask}, i_wb_dat, i_wb_sel);
						n.irq_mask = wmerge[IRQ_W-1:0];
					end
				end
				REG_HWY_STAT:
				begin
					// read only: a write is answered and dropped
					n.dat = 32'h0;
					n.dat[HST_CYC_LO +: CYC_W] = q.cyc;
					n.dat[HST_MASTER] = master;
					n.dat[HST_RATE_ERR] = q.rate_err;
					n.dat[HST_LOCKED] = q.locked;
				end
				default:
				begin
					// unmapped: answered with zero so a stray access never hangs the bus
					n.dat = 32'h0;
				end
			endcase
		end

		// sticky status, a new event wins over a clear
		n.irq_stat = (q.irq_stat & ~clr) | set;
		// the level follows new status and mask together, no extra cycle
		n.irq = |(n.irq_stat & n.irq_mask);

		// pin drivers: master drives clock and sync
		n.bck_o = master & gen_if.bck;
		// the enables follow the mode one cycle after a command write
		n.bck_oe_b = ~master;
		n.fs_o = master & gen_if.fs;
		n.fs_oe_b = ~master;
		// open drain pulls low only, push pull always drives
		if (q.cmd[CMD_OPEN_DRAIN])
		begin
			n.txd_o = 1'b0;
			n.txd_oe_b = i_tx_bit;
		end
		else
		begin
			n.txd_o = i_tx_bit;
			n.txd_oe_b = 1'b0;
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			// every pin starts released; push-pull data drives from the first edge on
			q <= '0;
			q.cmd <= CMD_RESET;
			q.irq_stat <= IRQ_RESET;
			q.irq_mask <= IRQ_RESET;
			q.bck_oe_b <= 1'b1;
			q.fs_oe_b <= 1'b1;
			q.txd_oe_b <= 1'b1;
		end
		else
			q <= n;
	end

	// registered outputs
	assign o_wb_dat = q.dat;
	assign o_wb_ack = q.ack;
	assign o_highway_bit_clock = q.bck_o;
	assign o_highway_bit_clock_oe_b = q.bck_oe_b;
	assign o_highway_frame_sync = q.fs_o;
	assign o_highway_frame_sync_oe_b = q.fs_oe_b;
	assign o_highway_transmit_data = q.txd_o;
	assign o_highway_transmit_data_oe_b = q.txd_oe_b;
	assign o_slot_cycle = q.cyc;
	assign o_frame_start = q.frame_start;
	assign o_irq = q.irq;

endmodule : thc_top

`default_nettype wire

// ### common/thc_pkg.sv
// Purpose: shared constants and helpers for the tdm highway clock and frame configuration block
// Assumes: 250 MHz system clock, 12.288 MHz reference sampled on that clock
// Notes: register byte offsets, command word fields, timing counts
`default_nettype none

package thc_pkg;

	// clock rates and frame time
	localparam int unsigned SYS_CLK_HZ = 250_000_000;
	localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
	localparam int unsigned FRAME_US = 125;
	localparam int unsigned FRAME_CYC = (FRAME_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned FS_TOL_NS = 200;
	localparam int unsigned FS_TOL_CYC = (FS_TOL_NS / CLK_PERIOD_NS) > 0 ? (FS_TOL_NS / CLK_PERIOD_NS) : 1;

	// register byte offsets
	localparam int ADR_W = 4;
	localparam logic [ADR_W-1:0] REG_CMD = 4'h0;
	localparam logic [ADR_W-1:0] REG_IRQ_STAT = 4'h4;
	localparam logic [ADR_W-1:0] REG_IRQ_MASK = 4'h8;
	localparam logic [ADR_W-1:0] REG_HWY_STAT = 4'hc;

	// command word layout
	localparam int CMD_OPC_HI = 31;
	localparam int CMD_OPC_LO = 28;
	localparam logic [3:0] CMD_OPCODE = 4'h9;
	localparam int CMD_MODE_HI = 23;
	localparam int CMD_MODE_LO = 16;
	localparam int CMD_REPORT = 15;
	localparam int CMD_IRQ_EN = 14;
	localparam int CMD_OPEN_DRAIN = 13;
	localparam int CMD_SAMPLE_EDGE = 12;
	localparam int CMD_DRIVE_EDGE = 11;
	localparam int CMD_BPF_HI = 10;
	localparam int CMD_BPF_LO = 0;
	localparam int BPF_W = CMD_BPF_HI - CMD_BPF_LO + 1;
	localparam logic [31:0] CMD_RESET = 32'h0000_0000;

	// clock mode values
	localparam logic [7:0] MODE_SLAVE_8K = 8'h00;
	localparam logic [7:0] MODE_SLAVE_FREE = 8'h01;
	localparam logic [7:0] MODE_MASTER_MIN = 8'h03;

	// interrupt status bits
	localparam int IRQ_W = 2;
	localparam int IRQ_HWY_STATUS = 0;
	localparam int IRQ_CMD_REJECT = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

	// highway status word layout
	localparam int HST_LOCKED = 0;
	localparam int HST_RATE_ERR = 1;
	localparam int HST_MASTER = 2;
	localparam int HST_CYC_LO = 14;
	localparam int CYC_W = 10;

	// generator states, gray along wait, high, low
	typedef enum logic [1:0]
	{
		GS_WAIT = 2'b00,
		GS_HIGH = 2'b01,
		GS_LOW = 2'b11
	} thc_gen_st_e;

	// a clock mode of three or more makes the device drive the highway
	function automatic logic thc_is_master(input logic [7:0] mode);
		return mode >= MODE_MASTER_MIN;
	endfunction : thc_is_master

	// byte lane merge for wishbone writes
	function automatic logic [31:0] thc_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = wr[i*8 +: 8];
		end
		return r;
	endfunction : thc_merge

endpackage : thc_pkg

`default_nettype wire

// ### common/thc_gen_if.sv
// Purpose: link between the control core and the master clock generator
// Assumes: one clock domain
// Notes: control side drives configuration and reference tick
`default_nettype none

interface thc_gen_if;
	logic run;
	logic [7:0] div;
	logic [10:0] bits_per_frame_count;
	logic drive_rise;
	logic ref_tick;
	logic bck;
	logic fs;
	modport gen (input run, input div, input bits_per_frame_count, input drive_rise, input ref_tick, output bck, output fs);
	modport ctl (output run, output div, output bits_per_frame_count, output drive_rise, output ref_tick, input bck, input fs);
endinterface : thc_gen_if

`default_nettype wire

// ### hw/thc_clkgen.sv
// Purpose: master mode bit clock and frame sync generator
// Assumes: ref_tick marks each rising edge of the reference
// Notes: frame length counted on the system clock, independent of divider and pulse count
`default_nettype none

module thc_clkgen
	import thc_pkg::*;
#(
	parameter int unsigned FRAME_CYC_P = FRAME_CYC
)
(
	input wire logic i_mclk, // system clock
	input wire logic i_rst_b, // async reset, active low
	thc_gen_if.gen gen // configuration in, clock and sync out
);
	localparam int FRW = $clog2(FRAME_CYC_P + 1);

	typedef struct packed
	{
		logic [FRW-1:0] frame_cnt;
		logic [7:0] div_cnt;
		logic [BPF_W:0] pulses;
		logic [CYC_W-1:0] per_cnt;
		thc_gen_st_e st;
		logic arm;
		logic bck;
		logic fs;
	} thc_gen_s;

	thc_gen_s q;
	thc_gen_s n;
	logic [7:0] cnt_inc;

	// next state of the generator
	always_comb
	begin
		n = q;
		cnt_inc = q.div_cnt + 8'h01;
		if (!gen.run)
		begin
			n = '0;
			n.st = GS_WAIT;
		end
		else
		begin
			// frame period fixed, never stretched by the pulse count
			if (q.frame_cnt == FRW'(FRAME_CYC_P - 1))
			begin
				n.frame_cnt = '0;
				n.arm = 1'b1;
			end
			else
				n.frame_cnt = q.frame_cnt + 1'b1;
			if (gen.ref_tick)
			begin
				if (q.arm)
				begin
					// first bit clock period of the frame
					n.arm = 1'b0;
					n.div_cnt = 8'h00;
					n.per_cnt = '0;
					n.pulses = (BPF_W+1)'(1);
					n.bck = 1'b1;
					n.fs = 1'b0;
					n.st = GS_HIGH;
				end
				else
				begin
					case (q.st)
						GS_WAIT:
						begin
							n.st = GS_WAIT;
						end
						GS_HIGH, GS_LOW:
						begin
							n.div_cnt = cnt_inc;
							if (q.st == GS_HIGH && cnt_inc == (gen.div >> 1))
							begin
								// falling edge of the bit clock
								n.bck = 1'b0;
								n.st = GS_LOW;
								if (!gen.drive_rise && q.per_cnt == CYC_W'(0))
									n.fs = 1'b1;
								if (!gen.drive_rise && q.per_cnt == CYC_W'(1))
									n.fs = 1'b0;
							end
							if (cnt_inc == gen.div)
							begin
								// start of the next period
								n.div_cnt = 8'h00;
								n.st = GS_HIGH;
								if (q.per_cnt != '1)
									n.per_cnt = q.per_cnt + 1'b1;
								// pulses beyond the count leave the clock low
								if (q.pulses <= {1'b0, gen.bits_per_frame_count})
								begin
									n.bck = 1'b1;
									n.pulses = q.pulses + 1'b1;
								end
								if (gen.drive_rise && q.per_cnt == CYC_W'(0))
									n.fs = 1'b1;
								if (gen.drive_rise && q.per_cnt == CYC_W'(1))
									n.fs = 1'b0;
							end
						end
						default:
						begin
							n.st = GS_WAIT;
						end
					endcase
				end
			end
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			q <= '0;
			q.st <= GS_WAIT;
		end
		else
			q <= n;
	end

	assign gen.bck = q.bck;
	assign gen.fs = q.fs;

endmodule : thc_clkgen

`default_nettype wire

// ### tb/thc_top_monitor.sv
// Purpose: port checks of thc_top
// Assumes: one clock, async reset active low
// Notes: bound to every thc_top
`default_nettype none
module thc_top_monitor
	import thc_pkg::*;
#(
	parameter int unsigned FRAME_CYC_P = FRAME_CYC
)
(
	input wire logic i_mclk, // clock
	input wire logic i_rst_b, // reset
	input wire logic i_wb_cyc, // cycle
	input wire logic i_wb_stb, // strobe
	input wire logic i_wb_we, // write
	input wire logic o_wb_ack, // ack
	input wire logic i_tx_bit, // data in
	input wire logic o_highway_transmit_data, // data out
	input wire logic o_highway_transmit_data_oe_b, // data enable
	input wire logic o_highway_bit_clock, // clock out
	input wire logic o_highway_bit_clock_oe_b, // clock enable
	input wire logic o_highway_frame_sync, // sync out
	input wire logic o_highway_frame_sync_oe_b, // sync enable
	input wire logic [CYC_W-1:0] o_slot_cycle, // slot count
	input wire logic o_frame_start, // frame pulse
	input wire logic o_irq // interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LO = FRAME_CYC_P - 25;
	localparam int HI = FRAME_CYC_P + 25;
	int gap_q;
	logic arm_q;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);
	// cycles since frame start, armed only over undisturbed master frames
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			gap_q <= 0;
			arm_q <= 1'b0;
		end
		else
		begin
			gap_q <= o_frame_start ? 0 : gap_q + 1;
			if (o_highway_bit_clock_oe_b || (i_wb_cyc && i_wb_we))
				arm_q <= 1'b0;
			else if (o_frame_start)
				arm_q <= 1'b1;
		end
	end
	AST_ACK_ANSWER: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("ack late");
	AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack too long");
	AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without request");
	AST_TXD_LEVEL: assert property (!o_highway_transmit_data_oe_b |-> o_highway_transmit_data == $past(i_tx_bit))
		else $error("driven data wrong");
	AST_TXD_RELEASE: assert property (o_highway_transmit_data_oe_b |-> !o_highway_transmit_data)
		else $error("released data high");
	AST_SLAVE_QUIET: assert property (o_highway_bit_clock_oe_b |-> !o_highway_bit_clock && !o_highway_frame_sync)
		else $error("slave drives values");
	AST_OE_PAIR: assert property (o_highway_bit_clock_oe_b == o_highway_frame_sync_oe_b)
		else $error("clock and sync enables differ");
	AST_SLOT_STEP: assert property ($changed(o_slot_cycle) |-> o_slot_cycle == $past(o_slot_cycle) + 10'h1 || o_slot_cycle == 10'h0)
		else $error("slot count jumped");
	AST_FS_PULSE: assert property (o_frame_start |=> !o_frame_start)
		else $error("frame start too long");
	AST_FRAME_LEN: assert property (o_frame_start && arm_q |-> gap_q >= LO && gap_q <= HI)
		else $error("master frame length off");
	cover property (o_wb_ack && i_wb_we);
	cover property (o_frame_start && arm_q);
	cover property ($rose(o_irq));
endmodule : thc_top_monitor
bind thc_top thc_top_monitor #(.FRAME_CYC_P(FRAME_CYC_P)) u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack), .i_tx_bit(i_tx_bit),
	.o_highway_transmit_data(o_highway_transmit_data), .o_highway_transmit_data_oe_b(o_highway_transmit_data_oe_b),
	.o_highway_bit_clock(o_highway_bit_clock), .o_highway_bit_clock_oe_b(o_highway_bit_clock_oe_b),
	.o_highway_frame_sync(o_highway_frame_sync), .o_highway_frame_sync_oe_b(o_highway_frame_sync_oe_b),
	.o_slot_cycle(o_slot_cycle), .o_frame_start(o_frame_start), .o_irq(o_irq));
`default_nettype wire

// ### tb/thc_far_end.sv
// Purpose: far highway device giving bit clock and frame sync
// Assumes: bit clock of 16 system clocks
// Notes: released lines toggle every cycle
`default_nettype none
module thc_far_end
(
	input wire logic i_mclk, // clock
	input wire logic i_en, // drive highway
	input wire logic [15:0] i_gap, // clocks per frame
	output logic o_bck, // bit clock
	output logic o_fs // frame sync
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] c_q = 16'h0;
	logic tog_q = 1'b0;
	// twelve clocks at frame head, then the clock stands low
	always @(posedge i_mclk)
	begin
		c_q <= (c_q + 16'h1 >= i_gap) ? 16'h0 : c_q + 16'h1;
		tog_q <= ~tog_q;
		o_bck <= i_en ? (c_q < 16'h00c0 && c_q[3]) : tog_q;
		o_fs <= i_en ? (c_q >= 16'h000c && c_q < 16'h001c) : ~tog_q;
	end
endmodule : thc_far_end
`default_nettype wire

// ### tb/testbench.sv
// Purpose: self-checking bench of thc_top
// Assumes: frame shortened to 600 clocks
// Notes: far end supplies slave timing
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench
	import thc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FR = 600;
	logic i_mclk = 1'b0, i_ref_clk = 1'b0, i_rst_b = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [ADR_W-1:0] i_wb_adr = '0;
	logic [3:0] i_wb_sel = 4'hf;
	logic [31:0] i_wb_dat = '0, o_wb_dat;
	logic o_wb_ack, i_highway_bit_clock, o_highway_bit_clock, o_highway_bit_clock_oe_b, i_highway_frame_sync;
	logic o_highway_frame_sync, o_highway_frame_sync_oe_b, o_highway_transmit_data, o_highway_transmit_data_oe_b;
	logic i_tx_bit = 1'b0, o_frame_start, o_irq, m_en = 1'b0, m_bck, m_fs, bck_at, bck_q, fs_q;
	logic [CYC_W-1:0] o_slot_cycle, peak = '0, peak_l = '0;
	logic [15:0] m_gap = 16'h0258;
	int num_errors = 0, samples_checked = 0, frames = 0, fstarts = 0, rises = 0, gap = 0, per = 0;
	int pulses_l, gap_l, per_l, per_f;
	thc_top #(.FRAME_CYC_P(FR), .FS_TOL_P(4)) dut (.i_mclk, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
		.i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_ref_clk, .i_highway_bit_clock, .o_highway_bit_clock,
		.o_highway_bit_clock_oe_b, .i_highway_frame_sync, .o_highway_frame_sync, .o_highway_frame_sync_oe_b,
		.i_tx_bit, .o_highway_transmit_data, .o_highway_transmit_data_oe_b, .o_slot_cycle, .o_frame_start, .o_irq);
	thc_far_end far (.i_mclk, .i_en(m_en), .i_gap(m_gap), .o_bck(m_bck), .o_fs(m_fs));
	// pin levels from whoever drives
	assign i_highway_bit_clock = o_highway_bit_clock_oe_b ? m_bck : o_highway_bit_clock;
	assign i_highway_frame_sync = o_highway_frame_sync_oe_b ? m_fs : o_highway_frame_sync;
	always #2 i_mclk = ~i_mclk;
	always #40.690 i_ref_clk = ~i_ref_clk;
	// random data and per-frame measurements
	always @(posedge i_mclk)
	begin
		i_tx_bit <= 1'($urandom);
		bck_q <= o_highway_bit_clock;
		fs_q <= o_highway_frame_sync;
		gap++;
		per++;
		if (o_highway_bit_clock && !bck_q)
		begin
			rises++;
			per_l = per;
			per = 0;
		end
		if (o_highway_frame_sync && !fs_q)
		begin
			pulses_l = rises;
			gap_l = gap;
			per_f = per_l;
			bck_at = o_highway_bit_clock;
			rises = 0;
			gap = 0;
			frames++;
		end
		if (o_frame_start)
		begin
			peak_l = peak;
			peak = '0;
			fstarts++;
		end
		else if (o_slot_cycle > peak)
			peak = o_slot_cycle;
	end
	function automatic logic [31:0] cmd(input logic [7:0] md, input logic [4:0] fl, input logic [10:0] cnt);
		return {CMD_OPCODE, 4'h0, md, fl, cnt};
	endfunction : cmd
	function automatic int per_exp(input int md);
		return md * 250000 / 12288;
	endfunction : per_exp
	task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_mclk);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we <= w;
		i_wb_adr <= a;
		i_wb_dat <= d;
		do begin @(posedge i_mclk); n++; end while (o_wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
			num_errors++;
		q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
	endtask : wb
	task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [ADR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		`CHK(nm, e, q & m)
	endtask : rdc
	task automatic wt(input bit master, input int n);
		int s;
		int k;
		s = master ? frames : fstarts;
		for (k = 0; k < 20000 && (master ? frames : fstarts) < s + n; k++)
			@(posedge i_mclk);
		if (k >= 20000)
			num_errors++;
	endtask : wt
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// hang guard
	initial
	begin
		#400us;
		num_errors++;
		tally_and_finish();
	end
	// main sequence
	initial
	begin
		logic [CYC_W-1:0] pk [2][2];
		logic [10:0] cnt;
		logic [7:0] md;
		void'($urandom(95910));
		repeat (2) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rdc("cmd", REG_CMD, '1, CMD_RESET);
		rdc("stat", REG_IRQ_STAT, 32'h3, 32'h0);
		rdc("mask", REG_IRQ_MASK, 32'h3, 32'h0);
		rdc("unmapped", 4'h2, '1, 32'h0);
		`CHK("clock enable", 1'b1, o_highway_bit_clock_oe_b)
		// wrong opcode refused and flagged, then unmasked and cleared
		wr(REG_CMD, 32'h8003_0000);
		rdc("cmd", REG_CMD, '1, CMD_RESET);
		rdc("stat", REG_IRQ_STAT, 32'h3, 32'h2);
		`CHK("irq", 1'b0, o_irq)
		wr(REG_IRQ_MASK, 32'h2);
		repeat (2) @(posedge i_mclk);
		`CHK("irq", 1'b1, o_irq)
		wr(REG_IRQ_STAT, 32'h2);
		repeat (2) @(posedge i_mclk);
		`CHK("irq", 1'b0, o_irq)
		// slave at frame rate: sample edges and ignored count
		m_en <= 1'b1;
		for (int s = 0; s < 2; s++)
			for (int b = 0; b < 2; b++)
			begin
				cnt = b ? 11'h7ff : 11'($urandom_range(2046, 0));
				wr(REG_CMD, cmd(MODE_SLAVE_8K, {3'h0, s[0], 1'b0}, cnt));
				wt(1'b0, 3);
				pk[s][b] = peak_l;
			end
		`CHK("peak", pk[0][0], pk[0][1])
		`CHK("peak", pk[1][0], pk[1][1])
		`CHK("peak", pk[0][0] - 10'h1, pk[1][0])
		rdc("hwy", REG_HWY_STAT, 32'h7, 32'h1);
		// off-rate sync flagged only at the fixed-rate setting
		m_gap <= 16'h01c2;
		wt(1'b0, 4);
		rdc("rate", REG_HWY_STAT, 32'h2, 32'h2);
		wr(REG_CMD, cmd(MODE_SLAVE_FREE, 5'h0, 11'h0));
		wt(1'b0, 4);
		rdc("rate", REG_HWY_STAT, 32'h2, 32'h0);
		// report on demand, status events only when enabled
		wr(REG_IRQ_STAT, 32'h3);
		wr(REG_IRQ_MASK, 32'h1);
		wr(REG_CMD, cmd(MODE_SLAVE_FREE, 5'h10, 11'h0));
		repeat (2) @(posedge i_mclk);
		rdc("stat", REG_IRQ_STAT, 32'h1, 32'h0);
		`CHK("irq", 1'b0, o_irq)
		wr(REG_IRQ_STAT, 32'h1);
		m_gap <= 16'hffff;
		repeat (1500) @(posedge i_mclk);
		rdc("stat", REG_IRQ_STAT, 32'h1, 32'h0);
		`CHK("irq", 1'b0, o_irq)
		wr(REG_CMD, cmd(MODE_SLAVE_FREE, 5'h08, 11'h0));
		m_gap <= 16'h0258;
		wt(1'b0, 3);
		rdc("stat", REG_IRQ_STAT, 32'h1, 32'h1);
		// report on demand with the interrupt enabled
		wr(REG_IRQ_STAT, 32'h1);
		wr(REG_CMD, cmd(MODE_SLAVE_FREE, 5'h18, 11'h0));
		repeat (2) @(posedge i_mclk);
		rdc("stat", REG_IRQ_STAT, 32'h1, 32'h1);
		`CHK("irq", 1'b1, o_irq)
		// master: dividers, drive edges, counts, driver kinds
		m_en <= 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			md = 8'h03 + 8'(i[1]);
			cnt = (i == 4) ? 11'h7ff : 11'($urandom_range(5, 0));
			wr(REG_CMD, cmd(md, {2'h0, i[1], 1'b0, i[0]}, cnt));
			wt(1'b1, 3);
			`CHK("gap ok", 1'b1, gap_l >= FR - 25 && gap_l <= FR + 25)
			`CHK("clock enable", 1'b0, o_highway_bit_clock_oe_b)
			if (i[1])
				`CHK("open drain", 1'b0, o_highway_transmit_data)
			if (i < 4)
			begin
				`CHK("pulses", 32'(cnt) + 1, pulses_l)
				// a single pulse leaves the clock low when sync rises on a rising edge
				`CHK("drive edge", i[0] && cnt != 0, bck_at)
				if (i[0] && cnt != 0)
					`CHK("period ok", 1'b1, per_f >= per_exp(md) - 2 && per_f <= per_exp(md) + 2)
			end
		end
		rdc("hwy", REG_HWY_STAT, 32'h4, 32'h4);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
